/* hw/eeprom_host.sv */
// host controller driving a byte-wide parallel eeprom through its pins
// ==========================================================
// Functional notes
// RQ1: next page byte within byte-load window
// RQ2: page number lines constant during page load
// RQ3: output gate high while writing
// RQ4: one to 256 bytes per page load
// RQ5: lock prefix uses the command address sequence
// RQ6: page number constant after lock prefix
// RQ7: unlock ends with final byte, final address
// RQ8: data released within output float delay
// RQ9: read with select and gate low, strobe high
// RQ10: writes inhibited unless strobe, select low, gate high
// RQ11: window overrun starts device programming
// RQ12: poll bit reads complemented until programming ends
// RQ13: device ignores loads while programming
// RQ14: no new write before poll match or cycle time
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_host_cfg.svh"

module eeprom_host #(
	parameter int BLC_CYC = `BLC_CYC,
	parameter int WC_CYC  = `WC_CYC,
	parameter int TMR_W   = 21
) (
	// clock and reset
	input  wire logic                      mclk,
	input  wire logic                      reset_n,
	// command port
	input  wire logic                      cmd_valid,
	output var  logic                      cmd_ready,
	input  wire eeprom_host_pkg::host_op_e cmd_op,
	input  wire logic [`ADDR_W-1:0]        cmd_addr,
	input  wire logic [7:0]                cmd_data,
	input  wire logic                      cmd_last,
	// answer port
	output var  logic                      rsp_valid,
	output var  logic [7:0]                rsp_data,
	output var  logic                      busy,
	// device pins
	output var  logic                      ce_n,
	output var  logic                      oe_n,
	output var  logic                      we_n,
	output var  logic [`ADDR_W-1:0]        addr,
	output var  logic [7:0]                data_out,
	output var  logic                      data_oe,
	input  wire logic [7:0]                data_in
);
	import eeprom_host_pkg::*;

	if (BLC_CYC < `WP_CYC + `WPH_CYC + 2 || WC_CYC < 2 || WC_CYC >= 2 ** TMR_W || BLC_CYC >= 2 ** TMR_W)
	begin : g_bad_param
		$error("eeprom_host: timer parameters out of range");
	end

	// ==========================================================
	// reset release and pin synchroniser
	logic       rst_s1_q, rst_n;
	logic [7:0] din_s1_q, din_s2_q;

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_s1_q <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_n    <= rst_s1_q;
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			din_s1_q <= 8'h00;
			din_s2_q <= 8'h00;
		end
		else
		begin
			din_s1_q <= data_in;
			din_s2_q <= din_s1_q;
		end
	end

	// ==========================================================
	// command byte tables
	function automatic logic [`CMD_ADDR_W-1:0] seq_addr(input logic [2:0] idx);
		seq_addr = (idx == 3'h1 || idx == 3'h4) ? `CMD_ADDR_B : `CMD_ADDR_A;
	endfunction : seq_addr

	function automatic logic [7:0] seq_data(input prefix_e p, input logic [2:0] idx);
		unique case (idx)
			3'h0, 3'h3: seq_data = `CMD_D_FIRST;
			3'h1, 3'h4: seq_data = `CMD_D_SECOND;
			3'h2:       seq_data = (p == PFX_LOCK) ? `CMD_D_LOCK : `CMD_D_OPEN;
			default:    seq_data = `CMD_D_FINAL;
		endcase
	endfunction : seq_data

	// ==========================================================
	// sequencer state
	host_state_e                 state_q, state_d;
	prefix_e                     pfx_q, pfx_d;
	logic [2:0]                  seq_q, seq_d;
	logic [7:0]                  cnt_q, cnt_d;
	logic [`ADDR_W-1:0]          tgt_addr_q, tgt_addr_d;
	logic [7:0]                  tgt_data_q, tgt_data_d;
	logic [`ADDR_W-`PAGE_LSB-1:0] page_q, page_d;
	logic                        open_q, open_d;
	logic                        last_q, last_d;
	logic                        poll_q, poll_d;
	logic [8:0]                  nbytes_q, nbytes_d;
	logic                        ce_q, ce_d, oe_q, oe_d, we_q, we_d, doe_q, doe_d;
	logic [`ADDR_W-1:0]          addr_q, addr_d;
	logic [7:0]                  dout_q, dout_d;
	logic                        rspv_q, rspv_d;
	logic [7:0]                  rspd_q, rspd_d;
	logic                        tmr_start, tmr_long, tmr_done, byte_go, same_page;
	logic [TMR_W-1:0]            tmr_limit;

	eeprom_timer #(.W(TMR_W)) u_timer (
		.mclk  (mclk),
		.rst_n (rst_n),
		.start (tmr_start),
		.limit (tmr_limit),
		.done  (tmr_done)
	);

	// the window runs from each data strobe fall; polling timeout reuses it
	assign tmr_limit = tmr_long ? TMR_W'(WC_CYC) : TMR_W'(BLC_CYC);
	assign tmr_start = byte_go | tmr_long;
	assign same_page = cmd_addr[`ADDR_W-1:`PAGE_LSB] == page_q;
	assign cmd_ready = (state_q == ST_IDLE) ||
		(state_q == ST_OPEN && !tmr_done && cmd_op == OP_WRITE && same_page); // [RQ2] [RQ6]

	always_comb
	begin
		state_d = state_q;   pfx_d = pfx_q;   seq_d = seq_q;   cnt_d = cnt_q;
		tgt_addr_d = tgt_addr_q;   tgt_data_d = tgt_data_q;   page_d = page_q;
		open_d = open_q;   last_d = last_q;   poll_d = poll_q;   nbytes_d = nbytes_q;
		ce_d = ce_q;   oe_d = oe_q;   we_d = we_q;   doe_d = doe_q;
		addr_d = addr_q;   dout_d = dout_q;   rspv_d = 1'b0;   rspd_d = rspd_q;
		byte_go = 1'b0;   tmr_long = 1'b0;
		unique case (state_q)
			ST_IDLE, ST_OPEN:
			begin
				if (cmd_valid && cmd_ready)
				begin
					tgt_addr_d = cmd_addr;
					tgt_data_d = cmd_data;
					last_d     = cmd_last;
					seq_d      = 3'h0;
					state_d    = (cmd_op == OP_READ) ? ST_RD_LO : ST_WR_LO;
					poll_d     = 1'b0;
					pfx_d      = (cmd_op == OP_LOCK_WRITE) ? PFX_LOCK :
						(cmd_op == OP_UNLOCK) ? PFX_UNLOCK : PFX_NONE; // [RQ5]
					if (cmd_op != OP_READ && cmd_op != OP_UNLOCK && state_q == ST_IDLE)
					begin
						open_d   = 1'b1;
						page_d   = cmd_addr[`ADDR_W-1:`PAGE_LSB];
						nbytes_d = 9'h000;
					end
				end
				else if (state_q == ST_OPEN && (tmr_done || cmd_valid))
				begin
					// window lapsed or a foreign command: the page is closing, poll it
					state_d  = ST_RD_LO; // [RQ11]
					poll_d   = 1'b1;
					tmr_long = 1'b1;
				end
			end
			ST_WR_LO:
			begin
				if (cnt_q == 8'h00)
				begin
					we_d    = 1'b1;
					ce_d    = 1'b1;
					cnt_d   = 8'(`WPH_CYC - 1);
					state_d = ST_WR_HI;
				end
				else
					cnt_d = cnt_q - 8'h01;
			end
			ST_WR_HI:
			begin
				if (cnt_q != 8'h00)
					cnt_d = cnt_q - 8'h01;
				else if (pfx_q == PFX_NONE)
				begin
					nbytes_d = nbytes_q + 9'h001;
					doe_d    = 1'b0;
					if (last_q || nbytes_q + 9'h001 == 9'(`PAGE_BYTES))
					begin
						state_d  = ST_RD_LO; // [RQ4]
						poll_d   = 1'b1;
						tmr_long = 1'b1;
					end
					else
						state_d = ST_OPEN;
				end
				else if (pfx_q == PFX_UNLOCK && seq_q == `UNLOCK_LAST_IDX)
				begin
					doe_d    = 1'b0;
					pfx_d    = PFX_NONE;
					state_d  = ST_SETTLE; // [RQ7] [RQ14]
					tmr_long = 1'b1;
				end
				else
				begin
					if (pfx_q == PFX_LOCK && seq_q == `LOCK_LAST_IDX)
						pfx_d = PFX_NONE;
					seq_d   = seq_q + 3'h1;
					state_d = ST_WR_LO;
				end
			end
			ST_RD_LO:
			begin
				if (cnt_q == 8'h00)
				begin
					rspd_d  = din_s2_q;
					ce_d    = 1'b1;
					oe_d    = 1'b1;
					cnt_d   = 8'(`FLOAT_CYC - 1);
					state_d = ST_RD_HI;
				end
				else
					cnt_d = cnt_q - 8'h01;
			end
			ST_RD_HI:
			begin
				if (cnt_q != 8'h00)
					cnt_d = cnt_q - 8'h01;
				else if (!poll_q)
				begin
					rspv_d  = 1'b1;
					state_d = open_q ? ST_OPEN : ST_IDLE;
				end
				else if (rspd_q[`POLL_BIT] == tgt_data_q[`POLL_BIT] || tmr_done)
				begin
					open_d  = 1'b0; // [RQ12] [RQ14]
					state_d = ST_IDLE;
				end
				else
					state_d = ST_RD_LO;
			end
			ST_SETTLE:
			begin
				if (tmr_done)
				begin
					open_d  = 1'b0;
					state_d = ST_IDLE;
				end
			end
			default:
				state_d = ST_IDLE;
		endcase
		// pin values on entry to a strobe phase
		if (state_d == ST_WR_LO && state_q != ST_WR_LO)
		begin
			byte_go = pfx_d == PFX_NONE; // [RQ1]
			ce_d    = 1'b0;
			we_d    = 1'b0;
			oe_d    = 1'b1; // [RQ3]
			doe_d   = 1'b1;
			cnt_d   = 8'(`WP_CYC - 1);
			addr_d  = (pfx_d == PFX_NONE) ? tgt_addr_d :
				{tgt_addr_d[`ADDR_W-1:`CMD_ADDR_W], seq_addr(seq_d)}; // [RQ5]
			dout_d  = (pfx_d == PFX_NONE) ? tgt_data_d : seq_data(pfx_d, seq_d);
		end
		if (state_d == ST_RD_LO && state_q != ST_RD_LO)
		begin
			doe_d  = 1'b0;
			ce_d   = 1'b0;
			oe_d   = 1'b0;
			we_d   = 1'b1; // [RQ9]
			addr_d = tgt_addr_d;
			cnt_d  = 8'(`ACC_CYC - 1);
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= ST_IDLE;   pfx_q <= PFX_NONE;   seq_q <= 3'h0;   cnt_q <= 8'h00;
			tgt_addr_q <= '0;   tgt_data_q <= 8'h00;   page_q <= '0;   open_q <= 1'b0;
			last_q <= 1'b0;   poll_q <= 1'b0;   nbytes_q <= 9'h000;
			ce_q <= 1'b1;   oe_q <= 1'b1;   we_q <= 1'b1;   doe_q <= 1'b0;
			addr_q <= '0;   dout_q <= 8'h00;   rspv_q <= 1'b0;   rspd_q <= 8'h00;
		end
		else
		begin
			state_q <= state_d;   pfx_q <= pfx_d;   seq_q <= seq_d;   cnt_q <= cnt_d;
			tgt_addr_q <= tgt_addr_d;   tgt_data_q <= tgt_data_d;   page_q <= page_d;
			open_q <= open_d;   last_q <= last_d;   poll_q <= poll_d;   nbytes_q <= nbytes_d;
			ce_q <= ce_d;   oe_q <= oe_d;   we_q <= we_d;   doe_q <= doe_d;
			addr_q <= addr_d;   dout_q <= dout_d;   rspv_q <= rspv_d;   rspd_q <= rspd_d;
		end
	end

	assign ce_n      = ce_q;
	assign oe_n      = oe_q;
	assign we_n      = we_q;
	assign data_oe   = doe_q;
	assign addr      = addr_q;
	assign data_out  = dout_q;
	assign rsp_valid = rspv_q;
	assign rsp_data  = rspd_q;
	assign busy      = state_q != ST_IDLE;

	// ==========================================================
	// checks: helper counters
	logic [TMR_W-1:0] gap_q;
	logic [7:0]       flt_q;

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gap_q <= '0;
			flt_q <= 8'hFF;
		end
		else
		begin
			gap_q <= byte_go ? '0 : ((&gap_q) ? gap_q : gap_q + TMR_W'(1));
			flt_q <= !oe_q ? 8'h00 : ((&flt_q) ? flt_q : flt_q + 8'h01);
		end
	end

	chk_window_gap: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ1]
		byte_go && state_q == ST_OPEN |-> gap_q < TMR_W'(BLC_CYC))
		else $error("page byte started after the byte-load window");
	chk_page_stable: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ2]
		$fell(we_q) && pfx_q == PFX_NONE |-> addr_q[`ADDR_W-1:`PAGE_LSB] == page_q)
		else $error("page number lines changed within a page load");
	chk_gate_high: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ3]
		!we_q && !ce_q |-> oe_q && doe_q)
		else $error("output gate low during a write strobe");
	chk_page_count: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ4]
		open_q |-> nbytes_q <= 9'(`PAGE_BYTES))
		else $error("more than a page of bytes loaded");
	chk_lock_addr: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ5]
		$fell(we_q) && pfx_q != PFX_NONE |-> addr_q[`CMD_ADDR_W-1:0] == seq_addr(seq_q))
		else $error("command byte at the wrong address");
	chk_unlock_end: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ7]
		state_q == ST_WR_HI && state_d == ST_SETTLE |->
		dout_q == `CMD_D_FINAL && addr_q[`CMD_ADDR_W-1:0] == `CMD_ADDR_A)
		else $error("unlock sequence did not end with the final byte");
	chk_float_gap: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ8]
		$rose(doe_q) |-> flt_q >= 8'(`FLOAT_CYC))
		else $error("data driven before the device output floated");
	chk_busy_quiet: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ14]
		(state_q == ST_SETTLE || (poll_q && state_q == ST_RD_HI)) |-> we_q [*2])
		else $error("write strobe during a programming period");

endmodule : eeprom_host

`default_nettype wire

/* shared/eeprom_host_cfg.svh */
// constants for the parallel eeprom host controller
`ifndef EEPROM_HOST_CFG_SVH
`define EEPROM_HOST_CFG_SVH

// ==========================================================
// clock
`define CLK_NS           5
// ==========================================================
// pin timing in ns, as printed
`define T_WP_NS          100
`define T_WPH_NS         50
`define T_ACC_NS         200
`define T_FLOAT_NS       55
`define T_BLC_NS         150000
`define T_WC_NS          10000000
// ==========================================================
// derived cycle counts: least times and device delays round up (access gets two more), longest windows round down
`define WP_CYC           ((`T_WP_NS + `CLK_NS - 1) / `CLK_NS)
`define WPH_CYC          ((`T_WPH_NS + `CLK_NS - 1) / `CLK_NS)
`define ACC_CYC          ((`T_ACC_NS + `CLK_NS - 1) / `CLK_NS + 2)
`define FLOAT_CYC        ((`T_FLOAT_NS + `CLK_NS - 1) / `CLK_NS)
`define BLC_CYC          (`T_BLC_NS / `CLK_NS)
`define WC_CYC           (`T_WC_NS / `CLK_NS)
// ==========================================================
// geometry
`define ADDR_W           19
`define PAGE_LSB         8
`define PAGE_BYTES       256
`define CMD_ADDR_W       15
`define POLL_BIT         7
// ==========================================================
// write-lock command bytes
`define CMD_ADDR_A       15'h5555
`define CMD_ADDR_B       15'h2AAA
`define CMD_D_FIRST      8'hAA
`define CMD_D_SECOND     8'h55
`define CMD_D_LOCK       8'hA0
`define CMD_D_OPEN       8'h80
`define CMD_D_FINAL      8'h20
`define LOCK_LAST_IDX    3'h2
`define UNLOCK_LAST_IDX  3'h5

`endif

/* shared/eeprom_host_pkg.sv */
// types for the parallel eeprom host controller
`default_nettype none
package eeprom_host_pkg;

	typedef enum logic [1:0] {
		OP_READ       = 2'b00,
		OP_WRITE      = 2'b01,
		OP_LOCK_WRITE = 2'b10,
		OP_UNLOCK     = 2'b11
	} host_op_e;

	typedef enum logic [1:0] {
		PFX_NONE   = 2'b00,
		PFX_LOCK   = 2'b01,
		PFX_UNLOCK = 2'b10
	} prefix_e;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_OPEN   = 3'b001,
		ST_WR_LO  = 3'b010,
		ST_WR_HI  = 3'b011,
		ST_RD_LO  = 3'b100,
		ST_RD_HI  = 3'b101,
		ST_SETTLE = 3'b110
	} host_state_e;

endpackage : eeprom_host_pkg
`default_nettype wire

/* hw/eeprom_timer.sv */
// down-counting interval timer with a sticky done level
`timescale 1ns/1ps
`default_nettype none

module eeprom_timer #(
	parameter int W = 21
) (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         rst_n,
	// control
	input  wire logic         start,
	input  wire logic [W-1:0] limit,
	// status
	output var  logic         done
);

	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic         done_q;
	logic         done_d;

	always_comb
	begin
		cnt_d  = cnt_q;
		done_d = done_q;
		if (start)
		begin
			cnt_d  = limit;
			done_d = 1'b0;
		end
		else if (!done_q)
		begin
			if (cnt_q <= W'(1))
				done_d = 1'b1;
			else
				cnt_d = cnt_q - W'(1);
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q  <= '0;
			done_q <= 1'b1;
		end
		else
		begin
			cnt_q  <= cnt_d;
			done_q <= done_d;
		end
	end

	assign done = done_q;

endmodule : eeprom_timer

`default_nettype wire

/* test/eeprom_dev_model.sv */
// behavioural model of the byte-wide eeprom as seen at its pins
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_host_cfg.svh"

module eeprom_dev_model #(
	parameter int BLC_NS = 1000,
	parameter int WC_NS  = 1500
) (
	// strobes from the host
	input  wire logic        ce_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	// address and data
	input  wire logic [18:0] addr,
	input  wire logic [7:0]  din,
	input  wire logic        host_oe,
	output var  logic [7:0]  dout,
	output var  logic        drive,
	// pin rules broken by the host
	output var  int          viol
);
	logic [7:0]  mem [int];
	logic [7:0]  pend [int];
	logic [22:0] seq [6];
	logic [18:0] cap_a, last_a;
	logic [7:0]  cap_d, last_d;
	logic [10:0] page;
	logic        wr_act, loading, prog, locked, armed, unl;
	int          nb, cidx;
	realtime     last_t, prog_end;

	// ==========================================================
	// byte loading
	initial
	begin
		seq = '{{`CMD_ADDR_A, `CMD_D_FIRST}, {`CMD_ADDR_B, `CMD_D_SECOND}, {`CMD_ADDR_A, `CMD_D_OPEN},
			{`CMD_ADDR_A, `CMD_D_FIRST}, {`CMD_ADDR_B, `CMD_D_SECOND}, {`CMD_ADDR_A, `CMD_D_FINAL}};
		{loading, prog, locked, armed, unl} = 5'h00;
		nb = 0;
		cidx = 0;
		viol = 0;
	end
	assign wr_act = (ce_n === 1'b0) && (we_n === 1'b0) && (oe_n === 1'b1);
	always @*
		if (wr_act)
		begin
			cap_a = addr;
			cap_d = din;
		end
	// data taken at the end of the strobe, address held by then
	always @(negedge wr_act)
	begin
		if (prog)
			viol++;  // loads while programming are dropped
		else
		begin
			loading = 1'b1;
			last_t = $realtime;
			if ({cap_a[14:0], cap_d} === seq[cidx] || (cidx == 2 && {cap_a[14:0], cap_d} === {`CMD_ADDR_A, `CMD_D_LOCK}))
			begin
				if (cidx == 2 && cap_d === `CMD_D_LOCK)
				begin
					locked = 1'b1;
					armed = 1'b1;
					cidx = 0;
				end
				else if (cidx == 5)
				begin
					unl = 1'b1;
					cidx = 0;
				end
				else
					cidx++;
			end
			else
			begin
				// command bytes sit on other pages, so only data bytes pin the page
				if (nb > 0 && cap_a[18:8] !== page)
					viol++;
				if (nb == 0)
					page = cap_a[18:8];
				nb++;
				if (nb > `PAGE_BYTES)
					viol++;
				cidx = 0;
				pend[int'(cap_a)] = cap_d;
				last_a = cap_a;
				last_d = cap_d;
			end
		end
	end

	// ==========================================================
	// programming timer
	always #5
	begin
		if (loading && ($realtime - last_t) > BLC_NS)
		begin
			loading = 1'b0;
			prog = 1'b1;
			prog_end = $realtime + WC_NS;
		end
		else if (prog && $realtime >= prog_end)
		begin
			if (!locked || armed)
				foreach (pend[k])
					mem[k] = pend[k];  // whole page lands together
			pend.delete();
			locked = locked && !unl;
			{prog, armed, unl} = 3'h0;
			nb = 0;
		end
	end

	// ==========================================================
	// read side
	assign drive = (ce_n === 1'b0) && (oe_n === 1'b0) && (we_n === 1'b1);  // float at once
	always @*
	begin
		if ((loading || prog) && addr === last_a)
			dout = {~last_d[`POLL_BIT], last_d[6:0]};
		else if (mem.exists(int'(addr)))
			dout = mem[int'(addr)];
		else
			dout = addr[7:0] ^ 8'h5a;
	end
	always @(negedge we_n)
	begin
		#1;
		if (ce_n === 1'b0 && oe_n !== 1'b1)
			viol++;
	end
	// both sides driving the data lines is a clash
	always @(posedge drive or posedge host_oe)
	begin
		#1;
		if (drive && host_oe === 1'b1)
			viol++;
	end
endmodule : eeprom_dev_model
`default_nettype wire

/* test/testbench.sv */
// self-checking bench for the eeprom host controller
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_host_cfg.svh"

module testbench;
	import eeprom_host_pkg::*;
	logic              mclk, reset_n, cmd_valid, cmd_ready, cmd_last, rsp_valid, busy;
	host_op_e          cmd_op;
	logic [`ADDR_W-1:0] cmd_addr, addr;
	logic [7:0]        cmd_data, rsp_data, data_out, data_in, dev_q, float_q;
	logic              ce_n, oe_n, we_n, data_oe, dev_drive;
	int                viol, miscompares, compares;

	eeprom_host #(.BLC_CYC(200), .WC_CYC(1000), .TMR_W(21)) uut (.mclk(mclk), .reset_n(reset_n),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
		.cmd_last(cmd_last), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .busy(busy), .ce_n(ce_n), .oe_n(oe_n),
		.we_n(we_n), .addr(addr), .data_out(data_out), .data_oe(data_oe), .data_in(data_in));
	eeprom_dev_model #(.BLC_NS(1000), .WC_NS(1500)) dev (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr),
		.din(data_out), .host_oe(data_oe), .dout(dev_q), .drive(dev_drive), .viol(viol));
	// released lines never keep a stale value
	assign data_in = data_oe ? data_out : (dev_drive ? dev_q : ~float_q);
	always @(posedge mclk)
		float_q <= data_in;
	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// ==========================================================
	// helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t %s: got %0h expected %0h", $time, what, got, exp);
		end
	endtask : chk
	task automatic wait_lvl(ref logic sig, input logic lvl, input int lim);
		int n;
		n = 0;
		do
		begin
			@(negedge mclk);
			n++;
		end
		while (sig !== lvl && n < lim);
		if (sig !== lvl)
		begin
			miscompares++;
			$display("[FAIL] %0t wait ran out", $time);
			wrap_up();
		end
		@(posedge mclk);
	endtask : wait_lvl
	// valid is left high so page bytes can follow back to back
	task automatic send(input host_op_e op, input logic [18:0] a, input logic [7:0] d, input logic l);
		if (cmd_valid !== 1'b1)
			cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_addr <= a;
		cmd_data <= d;
		cmd_last <= l;
		wait_lvl(cmd_ready, 1'b1, 30000);
	endtask : send
	task automatic wr(input host_op_e op, input logic [18:0] a, input logic [7:0] d, input logic l);
		send(op, a, d, l);
		cmd_valid <= 1'b0;
		wait_lvl(busy, 1'b0, 4000);
	endtask : wr
	task automatic rd(input logic [18:0] a, input logic [7:0] exp);
		send(OP_READ, a, 8'h00, 1'b0);
		cmd_valid <= 1'b0;
		repeat (3) @(negedge mclk);
		chk({ce_n, oe_n, we_n, data_oe}, 4'h2, "read strobes");
		wait_lvl(rsp_valid, 1'b1, 200);
		chk(rsp_data, exp, "read data");
	endtask : rd

	// ==========================================================
	// scenarios
	task automatic t_idle();
		chk({ce_n, oe_n, we_n, data_oe, busy, cmd_ready}, 6'h39, "idle pins");
		rd(19'h1_2345, 8'h45 ^ 8'h5a);
		$display("%0t idle and read done", $time);
	endtask : t_idle
	task automatic t_page();
		for (int i = 0; i < 256; i++)
			send(OP_WRITE, {11'h0a5, i[7:0]}, i[7:0] ^ 8'hc3, 1'b0);
		cmd_valid <= 1'b0;
		wait_lvl(busy, 1'b0, 4000);
		rd({11'h0a5, 8'h00}, 8'hc3);
		rd({11'h0a5, 8'hff}, 8'hff ^ 8'hc3);
		chk(viol, 0, "pin rules in page load");
		$display("%0t full page done", $time);
	endtask : t_page
	task automatic t_window();
		wr(OP_WRITE, 19'h4_0010, 8'h96, 1'b0);
		rd(19'h4_0010, 8'h96);
		send(OP_WRITE, 19'h4_0020, 8'h5a, 1'b0);
		wr(OP_WRITE, 19'h5_0020, 8'h3c, 1'b1);
		rd(19'h4_0020, 8'h5a);
		rd(19'h5_0020, 8'h3c);
		chk(viol, 0, "pin rules in page switch");
		$display("%0t window lapse done", $time);
	endtask : t_window
	task automatic t_lock();
		wr(OP_LOCK_WRITE, 19'h2_0001, 8'h11, 1'b1);
		rd(19'h2_0001, 8'h11);
		wr(OP_WRITE, 19'h2_0002, 8'h22, 1'b1);
		rd(19'h2_0002, 8'h02 ^ 8'h5a);
		wr(OP_UNLOCK, 19'h2_0000, 8'h00, 1'b0);
		wr(OP_WRITE, 19'h2_0002, 8'h22, 1'b1);
		rd(19'h2_0002, 8'h22);
		chk(viol, 0, "pin rules in lock traffic");
		$display("%0t write lock done", $time);
	endtask : t_lock
	task automatic wrap_up();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : wrap_up

	initial
	begin
		reset_n = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = OP_READ;
		cmd_addr = '0;
		cmd_data = 8'h00;
		cmd_last = 1'b0;
		miscompares = 0;
		compares = 0;
		repeat (5) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (4) @(posedge mclk);
		t_idle();
		t_page();
		t_window();
		t_lock();
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
